// File: core/ise_io_status_led_encoder.sv
// Terminal status to four-digit seven-segment encoder with an AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ise_io_status_led_encoder
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ise_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ise_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire ise_pkg::ise_term_pins_t term_pins,
   input wire ise_pkg::ise_comm_cmd_t comm_command_word,
   output logic [31:0] led_segments
);
   localparam int PIN_W = $bits(ise_pkg::ise_term_pins_t);
   logic [PIN_W-1:0] s1_r, s2_r, s3_r, stable_r, stable_nxt;
   ise_pkg::ise_term_pins_t pins;
   logic [3:0] ctrl_r, ctrl_nxt;
   ise_pkg::ise_item_t item;
   logic [15:0] in_word, out_word, hex_word;
   logic [7:0] digit1;
   logic [31:0] seg_r, seg_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [ise_pkg::ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   // Conventional seven-segment glyph for one nibble, a in bit 0, dp left dark.
   function automatic logic [7:0] hex_glyph(input logic [3:0] n);
      logic [7:0] g;
      g = 8'h00;
      unique case (n)
         4'h0: g = 8'h3F;
         4'h1: g = 8'h06;
         4'h2: g = 8'h5B;
         4'h3: g = 8'h4F;
         4'h4: g = 8'h66;
         4'h5: g = 8'h6D;
         4'h6: g = 8'h7D;
         4'h7: g = 8'h07;
         4'h8: g = 8'h7F;
         4'h9: g = 8'h6F;
         4'hA: g = 8'h77;
         4'hB: g = 8'h7C;
         4'hC: g = 8'h39;
         4'hD: g = 8'h5E;
         4'hE: g = 8'h79;
         4'hF: g = 8'h71;
      endcase
      return g;
   endfunction

   // A pin change is accepted only once the second and third stages agree, so a
   // bouncing contact cannot leave a half-taken value behind.
   always_comb
   begin
      stable_nxt = (stable_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         stable_r <= '0;
      end
      else
      begin
         s1_r <= term_pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         stable_r <= stable_nxt;
      end
   end

   assign pins = ise_pkg::ise_term_pins_t'(stable_r);
   assign item = ise_pkg::ise_item_t'(ctrl_r[1:0]);

   // Status words of the selected monitor item; the spare code falls back to local.
   always_comb
   begin
      in_word = 16'h0000;
      out_word = 16'h0000;
      unique case (item)
         ise_pkg::ITEM_OPTION:
         begin
            in_word = pins.option_input;
            out_word = {8'h00, pins.option_output};
         end
         ise_pkg::ITEM_LOCAL, ise_pkg::ITEM_COMM, ise_pkg::ITEM_SPARE:
         begin
            // Closed terminal reads one.
            in_word[ise_pkg::IN_FWD_BIT] = pins.forward_run_input;
            in_word[ise_pkg::IN_REV_BIT] = pins.backward_run_input;
            in_word[ise_pkg::IN_GEN_LSB +: 7] = pins.general_input;
            in_word[ise_pkg::IN_PERMIT_BIT] = pins.drive_permit;
            out_word[ise_pkg::OUT_TR_LSB +: 4] = pins.transistor_output;
            out_word[ise_pkg::OUT_RELAY_BIT] = pins.relay_output_5;
            out_word[ise_pkg::OUT_ALARM_BIT] = pins.alarm_relay_contact;
            if (item == ise_pkg::ITEM_COMM)
            begin
               // Commands pass at their own level, never inverted.
               in_word[ise_pkg::IN_COMM_LSB +: 3] = comm_command_word;
            end
         end
      endcase
   end

   // Digit drive; the dash pattern keeps an all-off display from looking unpowered.
   always_comb
   begin
      hex_word = ctrl_r[ise_pkg::CTRL_VIEW_BIT] ? out_word : in_word;
      digit1 = 8'h00;
      digit1[0] = in_word[8];
      digit1[ise_pkg::SEG_D] = in_word[ise_pkg::IN_PERMIT_BIT];
      digit1[ise_pkg::SEG_F +: 3] = in_word[ise_pkg::IN_COMM_LSB +: 3];
      if (ctrl_r[ise_pkg::CTRL_FMT_BIT])
      begin
         seg_nxt = {hex_glyph(hex_word[15:12]), hex_glyph(hex_word[11:8]),
                    hex_glyph(hex_word[7:4]), hex_glyph(hex_word[3:0])};
      end
      else if (item == ise_pkg::ITEM_OPTION)
      begin
         seg_nxt = {8'h00, out_word[7:0], in_word[15:8], in_word[7:0]};
      end
      else
      begin
         seg_nxt = {7'h00, out_word[ise_pkg::OUT_ALARM_BIT],
                    3'h0, out_word[4:0], digit1, in_word[7:0]};
      end
      if (!ctrl_r[ise_pkg::CTRL_FMT_BIT] && seg_nxt == 32'h00000000)
      begin
         seg_nxt = ise_pkg::SEG_ALL_DASH;
      end
   end

   // Bus channels: address and data are held until both arrived, then one answer.
   always_comb
   begin
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ctrl_nxt = ctrl_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (awvalid && awready_r)
      begin
         aw_held_nxt = 1'b1;
         awready_nxt = 1'b0;
         waddr_nxt = awaddr;
      end
      if (wvalid && wready_r)
      begin
         w_held_nxt = 1'b1;
         wready_nxt = 1'b0;
         wdata_nxt = wdata;
         wstrb0_nxt = wstrb[0];
      end
      if (aw_held_r && w_held_r && !bvalid_r)
      begin
         bvalid_nxt = 1'b1;
         bresp_nxt = (waddr_r[1:0] == 2'h0) ? ise_pkg::RESP_OKAY : ise_pkg::RESP_SLVERR;
         if (waddr_r == ise_pkg::ADDR_CTRL && wstrb0_r)
         begin
            ctrl_nxt = wdata_r[3:0];
         end
      end
      if (bvalid_r && bready)
      begin
         bvalid_nxt = 1'b0;
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         awready_nxt = 1'b1;
         wready_nxt = 1'b1;
      end
      if (arvalid && arready_r)
      begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = ise_pkg::RESP_OKAY;
         unique case (araddr)
            ise_pkg::ADDR_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
            ise_pkg::ADDR_IN_WORD: rdata_nxt = {16'h0000, in_word};
            ise_pkg::ADDR_OUT_WORD: rdata_nxt = {16'h0000, out_word};
            ise_pkg::ADDR_SEGMENTS: rdata_nxt = seg_r;
            default:
            begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = ise_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_r && rready)
      begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= 32'h00000000;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= ise_pkg::RESP_OKAY;
         ctrl_r <= ise_pkg::CTRL_RESET;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= ise_pkg::RESP_OKAY;
         seg_r <= ise_pkg::SEG_ALL_DASH;
      end
      else
      begin
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ctrl_r <= ctrl_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         seg_r <= seg_nxt;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign led_segments = seg_r;

   // Checks on the status words, on the display digits one cycle behind their inputs, and on the bus answers.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   unassigned_zero_a: assert property (
      item != ise_pkg::ITEM_OPTION |-> in_word[12] == 1'b0 && in_word[10:9] == 2'h0
         && out_word[15:9] == 7'h00 && out_word[7:5] == 3'h0)
      else $error("unassigned status bit set");
   run_bits_a: assert property (
      item == ise_pkg::ITEM_LOCAL |-> in_word[1:0] ==
         {pins.backward_run_input, pins.forward_run_input})
      else $error("run inputs misplaced");
   general_bits_a: assert property (
      item == ise_pkg::ITEM_LOCAL |-> in_word[8:2] == pins.general_input
         && in_word[11] == pins.drive_permit && in_word[15:13] == 3'h0)
      else $error("general inputs misplaced");
   out_word_a: assert property (
      item != ise_pkg::ITEM_OPTION |-> out_word[4:0] == {pins.relay_output_5,
         pins.transistor_output} && out_word[8] == pins.alarm_relay_contact) else $error("output word wrong");
   comm_bits_a: assert property (
      item == ise_pkg::ITEM_COMM |-> in_word[15:13] == comm_command_word)
      else $error("command bits not in normal logic");
   option_map_a: assert property (
      item == ise_pkg::ITEM_OPTION |-> in_word == pins.option_input
         && out_word == {8'h00, pins.option_output})
      else $error("option terminals misplaced");
   dash_show_a: assert property (
      !ctrl_r[2] && in_word == 16'h0000 && out_word == 16'h0000
         |=> seg_r == ise_pkg::SEG_ALL_DASH)
      else $error("all-off display not dashes");
   hex_zero_a: assert property (
      ctrl_r[2] && hex_word == 16'h0000 && $stable(ctrl_r) |=> seg_r == ise_pkg::SEG_ALL_ZERO)
      else $error("zero word not shown as four zeros");
   hex_msb_a: assert property (
      ctrl_r[2] && hex_word == 16'hA000 |=> seg_r[31:24] == 8'h77 && seg_r[23:0] == 24'h3F3F3F)
      else $error("top nibble glyph wrong");
   seg_local_a: assert property (
      !ctrl_r[2] && item == ise_pkg::ITEM_LOCAL && pins.drive_permit |=> seg_r[11] && !seg_r[29])
      else $error("permit segment wrong");
   seg_alarm_a: assert property (
      !ctrl_r[2] && item == ise_pkg::ITEM_LOCAL && pins.alarm_relay_contact
         |=> seg_r[31:24] == 8'h01)
      else $error("alarm segment wrong");
   seg_out_a: assert property (
      !ctrl_r[2] && item == ise_pkg::ITEM_LOCAL && out_word[4:0] != 5'h00
         |=> seg_r[20:16] == $past(out_word[4:0]) && seg_r[23:21] == 3'h0)
      else $error("output digit wrong");
   option_left_a: assert property (
      !ctrl_r[2] && item == ise_pkg::ITEM_OPTION && pins.option_output != 8'h00
         |=> seg_r[31:24] == 8'h00)
      else $error("left digit lit for option card");
   bresp_hold_a: assert property (
      bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
      else $error("write answer dropped early");
   rd_answer_a: assert property (
      arvalid && arready_r |=> rvalid_r ##0 !arready_r)
      else $error("read not answered next cycle");
   hex_view_c: cover property (ctrl_r[2] && seg_r != ise_pkg::SEG_ALL_ZERO);
   comm_view_c: cover property (item == ise_pkg::ITEM_COMM && seg_r[15:13] != 3'h0);
   option_view_c: cover property (item == ise_pkg::ITEM_OPTION && seg_r[15:8] != 8'h00);
   write_read_c: cover property (bvalid_r && bready ##[1:4] rvalid_r && rready);
endmodule
`default_nettype wire

// File: core/ise_pkg.sv
// Constants, field layouts and carrier types for the terminal status LED encoder.
// Overview of operation
// - Segment format and hexadecimal format both offered.
// - Two right digits show closed input circuits.
// - Third digit a-e shows transistor and relay outputs.
// - Left digit segment a shows alarm relay.
// - Everything off shows dashes on all digits in segment format.
// - Hex format shows 16-bit word, MSB left.
// - Unassigned status word bits always read zero.
// - Forward run bit 0, backward run bit 1.
// - General inputs bits 2-8, drive permit bit 11.
// - Input bit is one while terminal shorted.
// - Transistor outputs occupy output word bits 0-3.
// - Relay output 5 occupies output bit 4.
// - Alarm relay contact occupies output bit 8.
// - Comm view adds three commands, bits 13-15.
// - Comm commands shown in normal, uninverted logic.
// - Option inputs 1-16 on bits 0-15.
// - Option outputs on bits 0-7, left digit unused in segment format.
// - Separate local, comm and option monitor items.
package ise_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_IN_WORD = 4'h4;
   localparam logic [3:0] ADDR_OUT_WORD = 4'h8;
   localparam logic [3:0] ADDR_SEGMENTS = 4'hC;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CTRL_FMT_BIT = 2;
   localparam int CTRL_VIEW_BIT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int IN_FWD_BIT = 0;
   localparam int IN_REV_BIT = 1;
   localparam int IN_GEN_LSB = 2;
   localparam int IN_PERMIT_BIT = 11;
   localparam int IN_COMM_LSB = 13;
   localparam int OUT_TR_LSB = 0;
   localparam int OUT_RELAY_BIT = 4;
   localparam int OUT_ALARM_BIT = 8;
   localparam int SEG_D = 3;
   localparam int SEG_F = 5;
   localparam logic [31:0] SEG_ALL_DASH = 32'h40404040;
   localparam logic [31:0] SEG_ALL_ZERO = 32'h3F3F3F3F;

   typedef enum logic [1:0] {ITEM_LOCAL, ITEM_COMM, ITEM_OPTION, ITEM_SPARE} ise_item_t;

   typedef struct packed {
      logic alarm_relay_contact;
      logic relay_output_5;
      logic [3:0] transistor_output;
      logic drive_permit;
      logic [6:0] general_input;
      logic backward_run_input;
      logic forward_run_input;
      logic [15:0] option_input;
      logic [7:0] option_output;
   } ise_term_pins_t;

   typedef struct packed {
      logic fault_reset_command;
      logic comm_backward_command;
      logic comm_forward_command;
   } ise_comm_cmd_t;
endpackage

// File: sim/ise_term_model.sv
// Far-side model of the control terminals and the communications command word.
`timescale 1ns/1ps
`default_nettype none
module ise_term_model
(
   input wire logic aclk,
   input wire ise_pkg::ise_term_pins_t want_pins,
   input wire ise_pkg::ise_comm_cmd_t want_cmd,
   output var ise_pkg::ise_term_pins_t term_pins,
   output var ise_pkg::ise_comm_cmd_t comm_command_word
);
   // Levels move only just after an edge, as real contacts seen through a clean sampler would.
   always @(posedge aclk)
   begin
      term_pins <= want_pins;
      comm_command_word <= want_cmd;
   end
endmodule
`default_nettype wire

// File: sim/ise_io_status_led_encoder_bench.sv
// Self-checking bench for the terminal status LED encoder.
`timescale 1ns/1ps
`default_nettype none
module ise_io_status_led_encoder_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, led_segments, rd;
   logic [1:0] rs;
   ise_pkg::ise_term_pins_t want_pins = '0, term_pins;
   ise_pkg::ise_comm_cmd_t want_cmd = '0, comm_command_word;
   int n_mismatch = 0, comparisons = 0, cyc = 0;

   ise_io_status_led_encoder u_ise_io_status_led_encoder (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .term_pins(term_pins),
      .comm_command_word(comm_command_word), .led_segments(led_segments));
   ise_term_model u_ise_term_model (.aclk(aclk), .want_pins(want_pins), .want_cmd(want_cmd),
      .term_pins(term_pins), .comm_command_word(comm_command_word));

   // Free-running 100 MHz clock.
   always #5 aclk = ~aclk;

   // Watchdog: the whole run needs a few hundred cycles, so a hang is cut well before.
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         end_of_test();
      end
   end

   // Compare one value, counting every comparison and every mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One AXI4-Lite write; address and data offered together, released as each is taken.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   // One AXI4-Lite read; data and response taken at the edge where rvalid is seen.
   task automatic axi_rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // Conventional hexadecimal glyphs, segment a in bit 0.
   function automatic logic [7:0] glyph(input logic [3:0] v);
      logic [7:0] t [16];
      t = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
            8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
      return t[v];
   endfunction

   function automatic logic [31:0] hex4(input logic [15:0] w);
      return {glyph(w[15:12]), glyph(w[11:8]), glyph(w[7:4]), glyph(w[3:0])};
   endfunction

   // Pins cross a three-stage sampler and two registers, so allow them to settle.
   task automatic settle();
      repeat (8) @(posedge aclk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      settle();
      axi_rd(ise_pkg::ADDR_CTRL);
      chk(rd, 32'h0);
      chk(led_segments, 32'h40404040);
      $display("test reset done");

      // Local terminals in segment format, then in hexadecimal format for the input and output words.
      want_pins.forward_run_input <= 1'b1;
      want_pins.general_input <= 7'h41;
      want_pins.drive_permit <= 1'b1;
      want_pins.transistor_output <= 4'hA;
      want_pins.relay_output_5 <= 1'b1;
      want_pins.alarm_relay_contact <= 1'b1;
      settle();
      chk(led_segments, 32'h011A0905);
      axi_rd(ise_pkg::ADDR_IN_WORD);
      chk(rd, 32'h00000905);
      axi_rd(ise_pkg::ADDR_OUT_WORD);
      chk(rd, 32'h0000011A);
      axi_wr(ise_pkg::ADDR_CTRL, 32'h4);
      settle();
      chk(led_segments, hex4(16'h0905));
      axi_wr(ise_pkg::ADDR_CTRL, 32'hC);
      settle();
      chk(led_segments, hex4(16'h011A));
      axi_rd(ise_pkg::ADDR_SEGMENTS);
      chk(rd, hex4(16'h011A));
      $display("test local done");

      // Commands only: dashes in the local item, shown uninverted in the comm item.
      want_pins <= '0;
      want_cmd <= 3'b101;
      axi_wr(ise_pkg::ADDR_CTRL, 32'h0);
      settle();
      chk(led_segments, 32'h40404040);
      axi_wr(ise_pkg::ADDR_CTRL, 32'h1);
      settle();
      chk(led_segments, 32'h0000A000);
      axi_rd(ise_pkg::ADDR_IN_WORD);
      chk(rd, 32'h0000A000);
      axi_wr(ise_pkg::ADDR_CTRL, 32'h5);
      settle();
      chk(led_segments, hex4(16'hA000));
      $display("test comm done");

      // Option card terminals.
      want_cmd <= '0;
      want_pins.option_input <= 16'hA5C3;
      want_pins.option_output <= 8'h96;
      axi_wr(ise_pkg::ADDR_CTRL, 32'h2);
      settle();
      chk(led_segments, 32'h0096A5C3);
      axi_rd(ise_pkg::ADDR_OUT_WORD);
      chk(rd, 32'h00000096);
      axi_wr(ise_pkg::ADDR_CTRL, 32'h6);
      for (int v = 0; v < 16; v++)
      begin
         want_pins.option_input <= {4{v[3:0]}};
         settle();
         chk(led_segments, {4{glyph(v[3:0])}});
      end
      $display("test option done");

      // Bus corner cases: read-only write ignored, unaligned access refused.
      axi_wr(ise_pkg::ADDR_IN_WORD, 32'hFFFFFFFF);
      chk({30'h0, rs}, {30'h0, ise_pkg::RESP_OKAY});
      axi_rd(4'h1);
      chk({30'h0, rs}, {30'h0, ise_pkg::RESP_SLVERR});
      chk(rd, 32'h0);
      // Unaligned write is refused, and a write without byte lane 0 leaves control alone.
      axi_wr(4'h2, 32'h0);
      chk({30'h0, rs}, {30'h0, ise_pkg::RESP_SLVERR});
      axi_wr(ise_pkg::ADDR_CTRL, 32'h1, 4'hE);
      chk({30'h0, rs}, {30'h0, ise_pkg::RESP_OKAY});
      axi_rd(ise_pkg::ADDR_CTRL);
      chk(rd, 32'h6);
      // Spare item code falls back to the local view: no local terminal is on here.
      axi_wr(ise_pkg::ADDR_CTRL, 32'h3);
      settle();
      chk(led_segments, 32'h40404040);
      $display("test bus done");
      end_of_test();
   end
endmodule
`default_nettype wire
